// ===== hdl/tbt_pkg.sv
package tbt_pkg;

    // ************************************************************
    // Register map, byte addresses on the AXI4-Lite slave
    // ************************************************************
    localparam logic [7:0] OFS_TCS = 8'h00;
    localparam logic [7:0] OFS_CNT = 8'h04;
    localparam logic [7:0] OFS_MOD = 8'h08;
    localparam logic [7:0] OFS_CS0 = 8'h0C;
    localparam logic [7:0] OFS_CMP0 = 8'h10;
    localparam logic [7:0] OFS_CS1 = 8'h14;
    localparam logic [7:0] OFS_CMP1 = 8'h18;
    localparam logic [7:0] OFS_BRK = 8'h1C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TCS_FLAG = 7;
    localparam int TCS_IE = 6;
    localparam int TCS_HALT = 5;
    localparam int TCS_CLR = 4;
    localparam int CS_FLAG = 7;
    localparam int CS_IE = 6;
    localparam int CS_LINK = 5;
    localparam int CS_MSA = 4;
    localparam int CS_ELS_HI = 3;
    localparam int CS_ELS_LO = 2;
    localparam int CS_TOV = 1;
    localparam int CS_MAX = 0;
    localparam int BRK_BCE = 0;

    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic HALT_RST = 1'b1;
    localparam logic [2:0] PS_EXT = 3'h7;
    localparam logic [1:0] MODE_UNBUF = 2'h1;
    localparam logic [1:0] MODE_BUF = 2'h2;
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } tbt_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tbt_axi_rsp_t;

    typedef struct packed {
        logic flag;
        logic armed;
        logic ie;
        logic link;
        logic msa;
        logic [1:0] els;
        logic tov;
        logic maxd;
        logic [15:0] cmp;
        logic out;
        logic pin_prev;
    } tbt_chan_t;

    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ovf_flag;
        logic ovf_armed;
        logic ovf_ie;
        logic halt;
        logic [2:0] ps;
        logic [5:0] presc;
        logic [15:0] cnt;
        logic [15:0] modulo;
        tbt_chan_t [1:0] ch;
        logic last_sel;
        logic active_sel;
        logic bce;
        logic [2:0] ext_sync;
    } tbt_state_t;

endpackage

// ===== hdl/tbt_timer.sv
`timescale 1ns/10ps
module tbt_timer (
    input wire logic clock,
    input wire logic sys_rst,
    input wire tbt_pkg::tbt_axi_req_t axi_req,
    output tbt_pkg::tbt_axi_rsp_t axi_rsp,
    input wire logic [1:0] channel_pin_in,
    output logic [1:0] channel_pin_out,
    output logic [1:0] channel_pin_oe_n,
    input wire logic ext_count_clock_pin,
    output logic ext_clk_force_input,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active,
    output logic irq_overflow,
    output logic [1:0] irq_channel,
    output logic wake_request
);

    tbt_pkg::tbt_state_t s_reg;
    tbt_pkg::tbt_state_t s_next;
    logic aw_fire;
    logic w_fire;
    logic wr_fire;
    logic ar_fire;
    logic wr_en;
    logic rd_en;
    logic brk_lock;
    logic link;
    logic run;
    logic int_tick;
    logic ext_edge;
    logic tick;
    logic ovf_evt;
    logic clr_req;
    logic [5:0] presc_mask;
    logic [15:0] cmp_act;
    logic [1:0] oc_mode;
    logic [1:0] cap_mode;
    logic [1:0] cmp_evt;
    logic [1:0] cap_evt;
    logic [31:0] rd_data;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = d[7:0];
        end
        if (st[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= tbt_pkg::OFS_BRK);
    endfunction

    // ************************************************************
    // Bus handshake and timebase
    // ************************************************************
    assign aw_fire = axi_req.awvalid && !s_reg.aw_have && !s_reg.bvalid;
    assign w_fire = axi_req.wvalid && !s_reg.w_have && !s_reg.bvalid;
    assign wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
    assign ar_fire = axi_req.arvalid && !s_reg.rvalid;
    // Registers are closed to the processor in wait mode.
    assign wr_en = wr_fire && !wait_mode;
    assign rd_en = ar_fire && !wait_mode;
    assign brk_lock = break_active && !s_reg.bce;
    assign clr_req = wr_en && s_reg.aw_addr == tbt_pkg::OFS_TCS
                     && s_reg.wstrb[0] && s_reg.wdata[tbt_pkg::TCS_CLR];
    assign link = s_reg.ch[0].link;
    assign run = !s_reg.halt && !stop_mode && !break_active;
    assign presc_mask = 6'((7'h01 << s_reg.ps) - 7'h01);
    assign int_tick = (s_reg.presc & presc_mask) == presc_mask;
    assign ext_edge = s_reg.ext_sync[1] && !s_reg.ext_sync[2];
    assign tick = run && ((s_reg.ps == tbt_pkg::PS_EXT) ? ext_edge
                                                       : int_tick);
    assign ovf_evt = tick && (s_reg.cnt == s_reg.modulo);
    assign cmp_act = (link && s_reg.active_sel) ? s_reg.ch[1].cmp
                                                : s_reg.ch[0].cmp;
    // Buffer link wins over the low mode bit on channel 0.
    assign oc_mode[0] = link || s_reg.ch[0].msa;
    assign oc_mode[1] = !link && s_reg.ch[1].msa;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            logic rise;
            logic fall;
            logic [15:0] cval;
            assign rise = channel_pin_in[gi] && !s_reg.ch[gi].pin_prev;
            assign fall = !channel_pin_in[gi] && s_reg.ch[gi].pin_prev;
            assign cval = (gi == 0) ? cmp_act : s_reg.ch[1].cmp;
            assign cap_mode[gi] = !oc_mode[gi]
                                  && s_reg.ch[gi].els != tbt_pkg::ELS_OFF
                                  && !(gi == 1 && link);
            assign cmp_evt[gi] = tick && oc_mode[gi]
                                 && s_reg.cnt == cval;
            assign cap_evt[gi] = cap_mode[gi] && run
                && ((s_reg.ch[gi].els[0] && rise)
                    || (s_reg.ch[gi].els[1] && fall));
            assign channel_pin_out[gi] = s_reg.ch[gi].out;
            assign channel_pin_oe_n[gi] = !(oc_mode[gi]
                && s_reg.ch[gi].els != tbt_pkg::ELS_OFF);
            assign irq_channel[gi] = s_reg.ch[gi].flag
                                     && s_reg.ch[gi].ie;
        end
    endgenerate
    assign irq_overflow = s_reg.ovf_flag && s_reg.ovf_ie;
    assign wake_request = wait_mode && (irq_overflow || |irq_channel);
    assign ext_clk_force_input = s_reg.ps == tbt_pkg::PS_EXT;
    assign axi_rsp.awready = !s_reg.aw_have && !s_reg.bvalid;
    assign axi_rsp.wready = !s_reg.w_have && !s_reg.bvalid;
    assign axi_rsp.bvalid = s_reg.bvalid;
    assign axi_rsp.bresp = s_reg.bresp;
    assign axi_rsp.arready = !s_reg.rvalid;
    assign axi_rsp.rvalid = s_reg.rvalid;
    assign axi_rsp.rdata = s_reg.rdata;
    assign axi_rsp.rresp = s_reg.rresp;

    // ************************************************************
    // Read-back multiplexer
    // ************************************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (axi_req.araddr)
            tbt_pkg::OFS_TCS: rd_data[7:0] = {s_reg.ovf_flag, s_reg.ovf_ie,
                s_reg.halt, 2'h0, s_reg.ps};
            tbt_pkg::OFS_CNT: rd_data[15:0] = s_reg.cnt;
            tbt_pkg::OFS_MOD: rd_data[15:0] = s_reg.modulo;
            tbt_pkg::OFS_CS0: rd_data[7:0] = {s_reg.ch[0].flag,
                s_reg.ch[0].ie, s_reg.ch[0].link, s_reg.ch[0].msa,
                s_reg.ch[0].els, s_reg.ch[0].tov, s_reg.ch[0].maxd};
            tbt_pkg::OFS_CMP0: rd_data[15:0] = s_reg.ch[0].cmp;
            tbt_pkg::OFS_CS1: rd_data[7:0] = {s_reg.ch[1].flag,
                s_reg.ch[1].ie, 1'b0, s_reg.ch[1].msa,
                s_reg.ch[1].els, s_reg.ch[1].tov, s_reg.ch[1].maxd};
            tbt_pkg::OFS_CMP1: rd_data[15:0] = s_reg.ch[1].cmp;
            tbt_pkg::OFS_BRK: rd_data[0] = s_reg.bce;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.ext_sync = {s_reg.ext_sync[1:0], ext_count_clock_pin};
        if (aw_fire) begin
            s_next.aw_have = 1'b1;
            s_next.aw_addr = axi_req.awaddr;
        end
        if (w_fire) begin
            s_next.w_have = 1'b1;
            s_next.wdata = axi_req.wdata;
            s_next.wstrb = axi_req.wstrb;
        end
        if (wr_fire) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wait_mode ? tbt_pkg::RESP_SLVERR
                : (mapped(s_reg.aw_addr) ? tbt_pkg::RESP_OKAY
                                         : tbt_pkg::RESP_DECERR);
        end else if (s_reg.bvalid && axi_req.bready) begin
            s_next.bvalid = 1'b0;
        end
        if (ar_fire) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = wait_mode ? 32'h0000_0000 : rd_data;
            s_next.rresp = wait_mode ? tbt_pkg::RESP_SLVERR
                : (mapped(axi_req.araddr) ? tbt_pkg::RESP_OKAY
                                          : tbt_pkg::RESP_DECERR);
        end else if (s_reg.rvalid && axi_req.rready) begin
            s_next.rvalid = 1'b0;
        end

        // First step of each two-step flag clear: a read while set.
        if (rd_en && !brk_lock) begin
            if (axi_req.araddr == tbt_pkg::OFS_TCS && s_reg.ovf_flag) begin
                s_next.ovf_armed = 1'b1;
            end
            if (axi_req.araddr == tbt_pkg::OFS_CS0 && s_reg.ch[0].flag) begin
                s_next.ch[0].armed = 1'b1;
            end
            if (axi_req.araddr == tbt_pkg::OFS_CS1 && s_reg.ch[1].flag) begin
                s_next.ch[1].armed = 1'b1;
            end
        end
        // Prescaler and counter.
        if (run) begin
            s_next.presc = s_reg.presc + 6'h01;
        end
        if (tick) begin
            s_next.cnt = ovf_evt ? 16'h0000 : s_reg.cnt + 16'h0001;
        end
        if (wr_en && s_reg.aw_addr == tbt_pkg::OFS_TCS && s_reg.wstrb[0]) begin
            s_next.ovf_ie = s_reg.wdata[tbt_pkg::TCS_IE];
            s_next.halt = s_reg.wdata[tbt_pkg::TCS_HALT];
            s_next.ps = s_reg.wdata[2:0];
            if (!brk_lock) begin
                if (!s_reg.wdata[tbt_pkg::TCS_FLAG] && s_reg.ovf_armed) begin
                    s_next.ovf_flag = 1'b0;
                end
                s_next.ovf_armed = 1'b0;
            end
        end
        if (clr_req) begin
            s_next.cnt = 16'h0000;
            s_next.presc = 6'h00;
        end
        if (wr_en && s_reg.aw_addr == tbt_pkg::OFS_MOD) begin
            s_next.modulo = merge16(s_reg.modulo, s_reg.wdata, s_reg.wstrb);
        end
        if (wr_en && s_reg.aw_addr == tbt_pkg::OFS_BRK && s_reg.wstrb[0]) begin
            s_next.bce = s_reg.wdata[tbt_pkg::BRK_BCE];
        end
        // A new overflow beats a clear in the same cycle.
        if (ovf_evt) begin
            s_next.ovf_flag = 1'b1;
            s_next.ovf_armed = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            if (wr_en && s_reg.wstrb[0] && s_reg.aw_addr ==
                ((i == 0) ? tbt_pkg::OFS_CS0 : tbt_pkg::OFS_CS1)) begin
                s_next.ch[i].ie = s_reg.wdata[tbt_pkg::CS_IE];
                s_next.ch[i].msa = s_reg.wdata[tbt_pkg::CS_MSA];
                s_next.ch[i].els = s_reg.wdata[tbt_pkg::CS_ELS_HI:
                                               tbt_pkg::CS_ELS_LO];
                s_next.ch[i].tov = s_reg.wdata[tbt_pkg::CS_TOV];
                s_next.ch[i].maxd = s_reg.wdata[tbt_pkg::CS_MAX];
                if (i == 0) begin
                    s_next.ch[0].link = s_reg.wdata[tbt_pkg::CS_LINK];
                end
                if (!brk_lock) begin
                    if (!s_reg.wdata[tbt_pkg::CS_FLAG]
                        && s_reg.ch[i].armed) begin
                        s_next.ch[i].flag = 1'b0;
                    end
                    s_next.ch[i].armed = 1'b0;
                end
            end
            if (wr_en && s_reg.aw_addr ==
                ((i == 0) ? tbt_pkg::OFS_CMP0 : tbt_pkg::OFS_CMP1)) begin
                s_next.ch[i].cmp = merge16(s_reg.ch[i].cmp, s_reg.wdata,
                                           s_reg.wstrb);
                s_next.last_sel = (i == 1);
            end
            if (cap_evt[i]) begin
                s_next.ch[i].cmp = s_reg.cnt;
            end
            if (cap_evt[i] || cmp_evt[i]) begin
                s_next.ch[i].flag = 1'b1;
                s_next.ch[i].armed = 1'b0;
            end
            if (oc_mode[i]) begin
                if (ovf_evt && s_reg.ch[i].tov) begin
                    s_next.ch[i].out = !s_reg.ch[i].out;
                end
                if (cmp_evt[i]) begin
                    unique case (s_reg.ch[i].els)
                        tbt_pkg::ELS_TOGGLE:
                            s_next.ch[i].out = !s_reg.ch[i].out;
                        tbt_pkg::ELS_CLEAR: s_next.ch[i].out = 1'b0;
                        tbt_pkg::ELS_SET: s_next.ch[i].out = 1'b1;
                        tbt_pkg::ELS_OFF: s_next.ch[i].out = s_reg.ch[i].out;
                    endcase
                end
                if (s_reg.ch[i].maxd && !s_reg.ch[i].tov) begin
                    s_next.ch[i].out = !s_reg.ch[i].els[0];
                end
            end
            s_next.ch[i].pin_prev = channel_pin_in[i];
        end
        // Channel 0 starts in control; the latest write rules each period.
        if (!link) begin
            s_next.last_sel = 1'b0;
            s_next.active_sel = 1'b0;
        end else if (ovf_evt) begin
            s_next.active_sel = s_reg.last_sel;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.halt <= tbt_pkg::HALT_RST;
            s_reg.modulo <= tbt_pkg::MOD_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_ovf_wrap_flag: assert property (ovf_evt && !clr_req |=>
        s_reg.cnt == 16'h0000 && s_reg.ovf_flag)
        else $error("overflow did not wrap counter and set flag");
    a_ovf_flag_hold: assert property (s_reg.ovf_flag && !(wr_en
        && s_reg.aw_addr == tbt_pkg::OFS_TCS) |=> s_reg.ovf_flag)
        else $error("overflow flag cleared without a write");
    a_break_flag_keep: assert property (brk_lock && s_reg.ovf_flag
        |=> s_reg.ovf_flag)
        else $error("overflow flag changed in protected break");
    a_clear_zeroes: assert property (clr_req |=>
        s_reg.cnt == 16'h0000 && s_reg.presc == 6'h00)
        else $error("counter clear left counter or prescaler");
    a_break_freeze: assert property (break_active && !clr_req
        |=> $stable(s_reg.cnt))
        else $error("counter moved during break");
    a_stop_hold: assert property (stop_mode && !wr_fire && !clr_req
        |=> $stable(s_reg.cnt) && $stable(s_reg.ch[0].out))
        else $error("timer state changed in stop mode");
    a_link_select: assert property (link && ovf_evt
        |=> s_reg.active_sel == $past(s_reg.last_sel))
        else $error("linked overflow picked wrong compare source");
    a_ch1_release: assert property (link |-> channel_pin_oe_n[1])
        else $error("channel 1 pin driven while linked");
    a_max_duty: assert property (oc_mode[0] && s_reg.ch[0].maxd
        && !s_reg.ch[0].tov |=> s_reg.ch[0].out != $past(s_reg.ch[0].els[0]))
        else $error("maximum duty output not constant");
    a_no_toggle: assert property (oc_mode[0] && !s_reg.ch[0].tov
        && !s_reg.ch[0].maxd && !cmp_evt[0] |=> $stable(channel_pin_out[0]))
        else $error("output toggled with overflow toggle off");
    a_chan_flag: assert property (cmp_evt[0] || cap_evt[0]
        |=> s_reg.ch[0].flag)
        else $error("channel event did not set its flag");

    c_link_switch: cover property (link && ovf_evt && s_reg.last_sel);
    c_overflow: cover property (ovf_evt ##1 irq_overflow);
    c_capture: cover property (cap_evt[1]);
    c_full_duty: cover property (oc_mode[0] && s_reg.ch[0].maxd);

endmodule

// ===== sim/tbt_pin_model.sv
`timescale 1ns/10ps
// ********
// Pin side
// ********
module tbt_pin_model (
    input wire logic clock,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    output logic [1:0] pin_in,
    output logic ext_clk
);
    logic noise = 1'b0;
    logic cap_on = 1'b0;
    logic cap_lvl = 1'b0;
    initial ext_clk = 1'b0;
    // Released pins float, so they show a level that changes every cycle.
    // A source outside may drive the released channel 1 pin instead.
    always @(posedge clock) noise <= !noise;
    assign pin_in = (~pin_oe_n & pin_out)
        | (pin_oe_n & {cap_on ? cap_lvl : noise, !noise});
    // The high half lasts three clocks and the low half four; the pin idles low between bursts.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clock);
            ext_clk <= 1'b1;
            repeat (3) @(posedge clock);
            ext_clk <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
    // Puts a level on the channel 1 pin and keeps it there; returns two clocks later.
    task automatic drive_ch1(input logic v);
        @(posedge clock);
        cap_on <= 1'b1;
        cap_lvl <= v;
        repeat (2) @(posedge clock);
    endtask
endmodule

// ===== sim/two_channel_timer_buffered_pwm_tb.sv
`timescale 1ns/10ps
module two_channel_timer_buffered_pwm_tb;
    localparam int PER = 9;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    tbt_pkg::tbt_axi_req_t rq = '0;
    tbt_pkg::tbt_axi_rsp_t rs;
    logic [1:0] pin_in, pin_out, oe_n, irq_ch;
    logic ext_clk, force_in, wake, irq_ov;
    logic wait_mode = 1'b0, stop_mode = 1'b0, brk = 1'b0;
    logic [31:0] rd, a;
    logic [1:0] resp;
    int num_errors = 0, check_count = 0, seed = 14941, c, h;

    initial forever #10 clock = !clock;

    tbt_timer uut (.clock(clock), .sys_rst(sys_rst), .axi_req(rq),
        .axi_rsp(rs), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
        .channel_pin_oe_n(oe_n), .ext_count_clock_pin(ext_clk),
        .ext_clk_force_input(force_in), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .break_active(brk), .irq_overflow(irq_ov),
        .irq_channel(irq_ch), .wake_request(wake));
    tbt_pin_model pm (.clock(clock), .pin_out(pin_out), .pin_oe_n(oe_n),
        .pin_in(pin_in), .ext_clk(ext_clk));

    // ********
    // Helpers
    // ********
    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 100) begin
            num_errors++;
            $display("MISMATCH t=%0t bus timeout", $time);
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge clock);
        rq.awvalid <= 1'b1;
        rq.awaddr <= ad;
        rq.wvalid <= 1'b1;
        rq.wdata <= d;
        rq.wstrb <= 4'hF;
        rq.bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
            if (rs.bvalid) break;
        end
        rq.bready <= 1'b0;
        guard(n);
    endtask
    task automatic rdr(input logic [7:0] ad);
        int n;
        @(posedge clock);
        rq.arvalid <= 1'b1;
        rq.araddr <= ad;
        rq.rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (rs.arready) rq.arvalid <= 1'b0;
            if (rs.rvalid) break;
        end
        rd = rs.rdata;
        resp = rs.rresp;
        rq.rready <= 1'b0;
        guard(n);
    endtask
    // Counts high cycles of the channel 0 pin over ten PWM periods.
    task automatic cnt_hi;
        repeat (30) @(posedge clock);
        h = 0;
        repeat (100) begin
            @(posedge clock);
            if (pin_out[0] === 1'b1) h++;
        end
    endtask
    function automatic int f_duty(input int v);
        return (100 / (PER + 1)) * (v + 1);
    endfunction

    // ********
    // Sequence
    // ********
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        rdr(tbt_pkg::OFS_TCS);
        chk(rd, 32'h20);
        rdr(tbt_pkg::OFS_MOD);
        chk(rd, 32'hFFFF);
        wr(tbt_pkg::OFS_TCS, 32'h30);
        rdr(tbt_pkg::OFS_TCS);
        chk(rd, 32'h20);
        wr(tbt_pkg::OFS_MOD, PER);
        c = 1 + ({$random(seed)} % 7);
        wr(tbt_pkg::OFS_CMP0, c);
        wr(tbt_pkg::OFS_CS0, 32'h7A);
        wr(tbt_pkg::OFS_CS1, 32'h20);
        rdr(tbt_pkg::OFS_CS1);
        chk(rd[5], 1'b0);
        wr(tbt_pkg::OFS_TCS, 32'h40);
        chk(oe_n, 2'b10);
        cnt_hi();
        chk(h, f_duty(c));
        chk(irq_ch, 2'b01);
        chk(irq_ov, 1'b1);
        // Each new width goes to the compare value that is not in use.
        for (int i = 0; i < 4; i++) begin
            c = 1 + ({$random(seed)} % 7);
            wr(i[0] ? tbt_pkg::OFS_CMP0 : tbt_pkg::OFS_CMP1, c);
            cnt_hi();
            chk(h, f_duty(c));
        end
        wr(tbt_pkg::OFS_CS0, 32'h28);
        cnt_hi();
        chk(h, 0);
        wr(tbt_pkg::OFS_CS0, 32'h29);
        cnt_hi();
        chk(h, 100);
        @(posedge clock);
        brk <= 1'b1;
        rdr(tbt_pkg::OFS_CNT);
        a = rd;
        rdr(tbt_pkg::OFS_TCS);
        chk(rd[7], 1'b1);
        wr(tbt_pkg::OFS_TCS, 32'h40);
        rdr(tbt_pkg::OFS_TCS);
        chk(rd[7], 1'b1);
        rdr(tbt_pkg::OFS_CNT);
        chk(rd, a);
        brk <= 1'b0;
        wr(tbt_pkg::OFS_TCS, 32'hE0);
        rdr(tbt_pkg::OFS_TCS);
        chk(rd, 32'hE0);
        wr(tbt_pkg::OFS_TCS, 32'h60);
        rdr(tbt_pkg::OFS_TCS);
        chk(rd, 32'h60);
        chk(irq_ov, 1'b0);
        wr(tbt_pkg::OFS_TCS, 32'h40);
        stop_mode <= 1'b1;
        rdr(tbt_pkg::OFS_CNT);
        a = rd;
        rdr(tbt_pkg::OFS_CNT);
        chk(rd, a);
        stop_mode <= 1'b0;
        wait_mode <= 1'b1;
        rdr(tbt_pkg::OFS_TCS);
        chk(resp, tbt_pkg::RESP_SLVERR);
        repeat (20) @(posedge clock);
        chk(wake, 1'b1);
        wait_mode <= 1'b0;
        rdr(8'h40);
        chk(resp, tbt_pkg::RESP_DECERR);
        // With break clear enabled, a flag cleared in break stays cleared.
        wr(tbt_pkg::OFS_BRK, 32'h1);
        brk <= 1'b1;
        rdr(tbt_pkg::OFS_TCS);
        chk(rd[7], 1'b1);
        wr(tbt_pkg::OFS_TCS, 32'h60);
        brk <= 1'b0;
        rdr(tbt_pkg::OFS_TCS);
        chk(rd, 32'h60);
        wr(tbt_pkg::OFS_TCS, 32'h37);
        wr(tbt_pkg::OFS_TCS, 32'h07);
        chk(force_in, 1'b1);
        pm.pulses(5);
        rdr(tbt_pkg::OFS_CNT);
        chk(rd, 32'h5);
        // Unlinked channel 1 captures a rising edge, but not in break.
        pm.drive_ch1(1'b0);
        wr(tbt_pkg::OFS_CS0, 32'h00);
        wr(tbt_pkg::OFS_CS1, 32'h44);
        pm.drive_ch1(1'b1);
        rdr(tbt_pkg::OFS_CMP1);
        chk(rd, 32'h5);
        chk(irq_ch, 2'b10);
        pm.pulses(2);
        brk <= 1'b1;
        pm.drive_ch1(1'b0);
        pm.drive_ch1(1'b1);
        brk <= 1'b0;
        rdr(tbt_pkg::OFS_CMP1);
        chk(rd, 32'h5);
        // Unbuffered compare on channel 1 sets its pin at count 5.
        wr(tbt_pkg::OFS_CS1, 32'h1C);
        chk(oe_n[1], 1'b0);
        pm.pulses(9);
        chk(pin_out[1], 1'b1);
        report_and_stop();
    end
endmodule
